// [core/timer8_defs.vh]
// Register map, field positions, reset values and clock select codes of the 8-bit timer.
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH

// Word addresses (byte address = 4 * index).
`define ADDR_CTRL_A 3'h0
`define ADDR_CTRL_B 3'h1
`define ADDR_COUNTER 3'h2
`define ADDR_CMP_A 3'h3
`define ADDR_CMP_B 3'h4
`define ADDR_IRQ_MASK 3'h5
`define ADDR_IRQ_FLAGS 3'h6
`define ADDR_GLOBAL 3'h7

// Control B field positions.
`define BIT_FORCE_A 7
`define BIT_FORCE_B 6
`define BIT_WAVE_HI 3

// Control A field positions.
`define POS_ACT_A 6
`define POS_ACT_B 4

// Flag and mask positions.
`define BIT_CMP_B 2
`define BIT_CMP_A 1
`define BIT_OVF 0

// Reset value and counter limits.
`define RST_BYTE 8'h00
`define MAX_VALUE 8'hff
`define BOTTOM_VALUE 8'h00

// Clock select codes.
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// Prescaler width covers a divide by 1024.
`define PRESCALE_W 10

`endif

// [core/pin_sync_edge.v]
// Two-stage synchroniser of the count pin with edge detection.
module pin_sync_edge (
	input wire clk_i,
	input wire rst_b_i,
	input wire pin_i,
	output reg rise_o,
	output reg fall_o
);
	// First stage, read only by the second stage.
	reg meta_q;
	// Second stage, safe to use.
	reg sync_q;
	// Previous synchronised level for edge detection.
	reg prev_q;

	// Synchronise the pin and mark each edge for one cycle.
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
			rise_o <= sync_q & ~prev_q;
			fall_o <= ~sync_q & prev_q;
		end
	end
endmodule

// [core/tick_select.v]
// Prescaler and clock source selection producing the timer tick.
`include "timer8_defs.vh"
module tick_select (
	input wire clk_i,
	input wire rst_b_i,
	input wire [2:0] clock_source_sel_i,
	input wire ext_rise_i,
	input wire ext_fall_i,
	output reg tick_o
);
	// Free running prescaler count.
	reg [`PRESCALE_W-1:0] pre_q;
	// Next prescaler count, combinational.
	wire [`PRESCALE_W-1:0] pre_nxt = pre_q + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
	// Tick chosen this cycle.
	reg tick_d;

	// Choose the tick source from the select field.
	always @* begin
		case (clock_source_sel_i)
			`CS_STOP: tick_d = 1'b0;
			`CS_DIV1: tick_d = 1'b1;
			`CS_DIV8: tick_d = (pre_q[2:0] == 3'h7);
			`CS_DIV64: tick_d = (pre_q[5:0] == 6'h3f);
			`CS_DIV256: tick_d = (pre_q[7:0] == 8'hff);
			`CS_DIV1024: tick_d = (pre_q == 10'h3ff);
			`CS_EXT_FALL: tick_d = ext_fall_i;
			`CS_EXT_RISE: tick_d = ext_rise_i;
			default: tick_d = 1'b0;
		endcase
	end

	// Prescaler and registered tick.
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pre_q <= {`PRESCALE_W{1'b0}};
			tick_o <= 1'b0;
		end else begin
			pre_q <= pre_nxt;
			tick_o <= tick_d;
		end
	end
endmodule

// [core/timer8_ctrl_compare_flags.v]
// Top of the 8-bit timer: Avalon-MM registers, counter, compares, flags and wave outputs.
`include "timer8_defs.vh"
module timer8_ctrl_compare_flags (
	input wire clk_i,
	input wire rst_b_i,
	input wire [2:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire ext_count_pin_i,
	input wire [2:0] vector_ack_i,
	output reg wave_out_a_o,
	output reg wave_out_b_o,
	output reg [2:0] irq_req_o
);
	// Control A: output actions and lower wave mode bits.
	reg [1:0] out_action_a_q;
	reg [1:0] out_action_b_q;
	reg [1:0] wave_mode_lo_q;
	// Control B stored fields.
	reg wave_mode_hi_q;
	reg [2:0] clock_source_sel_q;
	// Counter and compare registers.
	reg [7:0] counter_value_q;
	reg [7:0] compare_a_value_q;
	reg [7:0] compare_b_value_q;
	// Interrupt enables and flags.
	reg [2:0] irq_en_q;
	reg [2:0] flags_q;
	// Global interrupt enable, status bit I.
	reg global_en_q;
	// Counting direction for phase correct modes, 1 while counting down.
	reg down_q;
	// Set by a counter write; blocks match on the next tick.
	reg block_q;
	// Answer phase flag: waitrequest drops one cycle after the request.
	reg ack_q;

	// Synchronised pin edges and the selected tick.
	wire ext_rise;
	wire ext_fall;
	wire tick;

	pin_sync_edge u_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.pin_i(ext_count_pin_i),
		.rise_o(ext_rise),
		.fall_o(ext_fall)
	);

	tick_select u_tick (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.clock_source_sel_i(clock_source_sel_q),
		.ext_rise_i(ext_rise),
		.ext_fall_i(ext_fall),
		.tick_o(tick)
	);

	// Full three-bit wave mode.
	wire [2:0] wave_mode = {wave_mode_hi_q, wave_mode_lo_q};
	// Mode classes.
	wire mode_pc = (wave_mode_lo_q == 2'h1);
	wire mode_fast = (wave_mode_lo_q == 2'h3);
	wire mode_ctc = (wave_mode == 3'h2);
	wire non_pwm = (wave_mode_lo_q == 2'h0) || (wave_mode_lo_q == 2'h2);
	// TOP value of the count sequence.
	wire [7:0] top_val = wave_mode_hi_q ? compare_a_value_q : `MAX_VALUE;

	// Writes take effect on the answer cycle, when waitrequest is low.
	wire wr_en = avs_write_i & ack_q & avs_byteenable_i[0];
	// Read data is loaded on the first request cycle, so it stands at the answer edge.
	wire rd_en = avs_read_i & ~ack_q;
	wire [7:0] wdata = avs_writedata_i[7:0];
	wire wr_ctrl_b = wr_en && (avs_address_i == `ADDR_CTRL_B);
	wire wr_cnt = wr_en && (avs_address_i == `ADDR_COUNTER);

	// Compare matches are valid only on a tick not blocked by a counter write.
	wire match_ok = tick & ~block_q;
	wire match_a = match_ok && (counter_value_q == compare_a_value_q);
	wire match_b = match_ok && (counter_value_q == compare_b_value_q);

	// Force strobes, honoured only in non-PWM modes.
	wire force_a = wr_ctrl_b & wdata[`BIT_FORCE_A] & non_pwm;
	wire force_b = wr_ctrl_b & wdata[`BIT_FORCE_B] & non_pwm;

	// Overflow event depending on wave mode.
	reg ovf_evt;
	always @* begin
		if (mode_pc) begin
			ovf_evt = tick && (counter_value_q == `BOTTOM_VALUE) && down_q;
		end else if (mode_fast) begin
			ovf_evt = tick && (counter_value_q == top_val);
		end else begin
			ovf_evt = tick && (counter_value_q == `MAX_VALUE) && !mode_ctc;
		end
		if (mode_ctc) begin
			ovf_evt = tick && (counter_value_q == `MAX_VALUE);
		end
	end

	// Next counter value per tick.
	reg [7:0] cnt_d;
	reg down_d;
	always @* begin
		cnt_d = counter_value_q;
		down_d = down_q;
		if (tick) begin
			if (mode_pc) begin
				// Phase correct: up to TOP, then down to BOTTOM.
				if (!down_q && counter_value_q == top_val) begin
					down_d = 1'b1;
					cnt_d = counter_value_q - 8'h01;
				end else if (down_q && counter_value_q == `BOTTOM_VALUE) begin
					down_d = 1'b0;
					cnt_d = counter_value_q + 8'h01;
				end else if (down_q) begin
					cnt_d = counter_value_q - 8'h01;
				end else begin
					cnt_d = counter_value_q + 8'h01;
				end
			end else if ((mode_fast && counter_value_q == top_val) || match_a & mode_ctc) begin
				// Real match (not a forced one) clears the counter in CTC.
				cnt_d = `BOTTOM_VALUE;
			end else begin
				cnt_d = counter_value_q + 8'h01;
			end
		end
	end

	// Output action for a channel given current action bits and event.
	function wave_next;
		input cur;
		input [1:0] act;
		input is_match;
		input at_bottom;
		input pc_mode;
		input fast_mode;
		input dir_down;
		begin
			wave_next = cur;
			if (is_match) begin
				case (act)
					2'h1: wave_next = (pc_mode | fast_mode) ? cur : ~cur;
					2'h2: wave_next = pc_mode ? dir_down : 1'b0;
					2'h3: wave_next = pc_mode ? ~dir_down : 1'b1;
					default: wave_next = cur;
				endcase
			end
			if (fast_mode && at_bottom && act[1]) begin
				wave_next = ~act[0];
			end
		end
	endfunction

	wire at_bottom = tick && (cnt_d == `BOTTOM_VALUE) && mode_fast;

	// Register file, counter, flags and outputs.
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			out_action_a_q <= 2'h0;
			out_action_b_q <= 2'h0;
			wave_mode_lo_q <= 2'h0;
			wave_mode_hi_q <= 1'b0;
			clock_source_sel_q <= `CS_STOP;
			counter_value_q <= `RST_BYTE;
			compare_a_value_q <= `RST_BYTE;
			compare_b_value_q <= `RST_BYTE;
			irq_en_q <= 3'h0;
			flags_q <= 3'h0;
			global_en_q <= 1'b0;
			down_q <= 1'b0;
			block_q <= 1'b0;
			ack_q <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
			avs_waitrequest_o <= 1'b1;
			wave_out_a_o <= 1'b0;
			wave_out_b_o <= 1'b0;
			irq_req_o <= 3'h0;
		end else begin
			// One wait cycle per access, then answer.
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_q);
			// Counter: a software write wins over a tick.
			down_q <= down_d;
			if (wr_cnt) begin
				counter_value_q <= wdata;
				block_q <= 1'b1;
			end else begin
				counter_value_q <= cnt_d;
				if (tick) begin
					block_q <= 1'b0;
				end
			end
			// Plain register writes.
			if (wr_en) begin
				case (avs_address_i)
					`ADDR_CTRL_A: begin
						out_action_a_q <= wdata[`POS_ACT_A+1:`POS_ACT_A];
						out_action_b_q <= wdata[`POS_ACT_B+1:`POS_ACT_B];
						wave_mode_lo_q <= wdata[1:0];
					end
					`ADDR_CTRL_B: begin
						wave_mode_hi_q <= wdata[`BIT_WAVE_HI];
						clock_source_sel_q <= wdata[2:0];
					end
					`ADDR_CMP_A: compare_a_value_q <= wdata;
					`ADDR_CMP_B: compare_b_value_q <= wdata;
					`ADDR_IRQ_MASK: irq_en_q <= wdata[2:0];
					`ADDR_GLOBAL: global_en_q <= wdata[0];
					default: global_en_q <= global_en_q;
				endcase
			end
			// Flags: set wins over write-one and vector clears; force sets none.
			flags_q[`BIT_CMP_B] <= match_b | (flags_q[`BIT_CMP_B] & ~vector_ack_i[`BIT_CMP_B]
				& ~(wr_en && avs_address_i == `ADDR_IRQ_FLAGS && wdata[`BIT_CMP_B]));
			flags_q[`BIT_CMP_A] <= match_a | (flags_q[`BIT_CMP_A] & ~vector_ack_i[`BIT_CMP_A]
				& ~(wr_en && avs_address_i == `ADDR_IRQ_FLAGS && wdata[`BIT_CMP_A]));
			flags_q[`BIT_OVF] <= ovf_evt | (flags_q[`BIT_OVF] & ~vector_ack_i[`BIT_OVF]
				& ~(wr_en && avs_address_i == `ADDR_IRQ_FLAGS && wdata[`BIT_OVF]));
			// Interrupt request needs enable, flag and global enable.
			irq_req_o <= irq_en_q & flags_q & {3{global_en_q}};
			// Wave outputs: forced compare uses current action bits.
			if (force_a) begin
				wave_out_a_o <= wave_next(wave_out_a_o, out_action_a_q, 1'b1, 1'b0, 1'b0, 1'b0,
					1'b0);
			end else begin
				wave_out_a_o <= wave_next(wave_out_a_o, out_action_a_q, match_a, at_bottom,
					mode_pc, mode_fast, down_q);
			end
			if (force_b) begin
				wave_out_b_o <= wave_next(wave_out_b_o, out_action_b_q, 1'b1, 1'b0, 1'b0, 1'b0,
					1'b0);
			end else begin
				wave_out_b_o <= wave_next(wave_out_b_o, out_action_b_q, match_b, at_bottom,
					mode_pc, mode_fast, down_q);
			end
			// Read data, reserved bits zero.
			if (rd_en) begin
				case (avs_address_i)
					`ADDR_CTRL_A: avs_readdata_o <= {24'h0, out_action_a_q, out_action_b_q, 2'h0,
						wave_mode_lo_q};
					`ADDR_CTRL_B: avs_readdata_o <= {24'h0, 2'h0, 2'h0, wave_mode_hi_q,
						clock_source_sel_q};
					`ADDR_COUNTER: avs_readdata_o <= {24'h0, counter_value_q};
					`ADDR_CMP_A: avs_readdata_o <= {24'h0, compare_a_value_q};
					`ADDR_CMP_B: avs_readdata_o <= {24'h0, compare_b_value_q};
					`ADDR_IRQ_MASK: avs_readdata_o <= {29'h0, irq_en_q};
					`ADDR_IRQ_FLAGS: avs_readdata_o <= {29'h0, flags_q};
					`ADDR_GLOBAL: avs_readdata_o <= {31'h0, global_en_q};
					default: avs_readdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// [tb/timer8_checker_properties.sv]
// Checker of the timer bus handshake, read-back fields and reset outputs.
module timer8_checker (
	input wire clk_i,
	input wire rst_b_i,
	input wire [2:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_readdata_o,
	input wire avs_waitrequest_o,
	input wire [2:0] irq_req_o,
	input wire wave_out_a_o,
	input wire wave_out_b_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// High at the edge where a read is answered.
	wire rd_ans = avs_read_i && !avs_waitrequest_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait low over one cycle");
	wait_cause_a: assert property (!avs_waitrequest_o |->
		(avs_read_i || avs_write_i) && $past(avs_read_i || avs_write_i))
		else $error("answer without request");
	req_answer_a: assert property (($rose(avs_read_i) || $rose(avs_write_i)) |=>
		!avs_waitrequest_o) else $error("answer late");
	upper_zero_a: assert property (rd_ans |-> avs_readdata_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	ctrl_b_res_a: assert property (rd_ans && avs_address_i == 3'h1 |->
		avs_readdata_o[7:4] == 4'h0) else $error("control b high bits set");
	irq_res_a: assert property (rd_ans && avs_address_i inside {3'h5, 3'h6} |->
		avs_readdata_o[7:3] == 5'h00) else $error("mask or flag high bits set");
	rdata_hold_a: assert property (!$stable(avs_readdata_o) |-> $past(avs_read_i))
		else $error("read data moved without read");
	reset_out_a: assert property ($rose(rst_b_i) |-> avs_waitrequest_o &&
		irq_req_o == 3'h0 && !wave_out_a_o && !wave_out_b_o) else $error("bad reset outputs");
endmodule
bind timer8_ctrl_compare_flags timer8_checker i_chk (.clk_i, .rst_b_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .irq_req_o,
	.wave_out_a_o, .wave_out_b_o);

// [tb/test_timer8_ctrl_compare_flags.sv]
// Self-checking bench of the 8-bit timer block.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_timer8_ctrl_compare_flags;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk_i = 0, rst_b_i = 0, rd = 0, wr = 0, pin = 0;
	reg [2:0] adr = 3'h0, ack = 3'h0;
	reg [7:0] wd = 8'h00, q;
	wire [31:0] rdat;
	wire wt, wa, wb;
	wire [2:0] irq;
	int n_errors = 0, num_checks = 0, cyc = 0;
	int dv[6] = '{0, 1, 8, 64, 256, 1024};
	timer8_ctrl_compare_flags i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i({24'h000000, wd}),
		.avs_byteenable_i(4'h1), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
		.ext_count_pin_i(pin), .vector_ack_i(ack), .wave_out_a_o(wa),
		.wave_out_b_o(wb), .irq_req_o(irq));
	initial forever #50 clk_i = ~clk_i;
	// Cuts a hung run short.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			test_done;
		end
	end
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// One bus access; held until waitrequest is seen low.
	task bus(input bit w, input [2:0] a, input [7:0] d);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wt !== 1'b0 && n < 20);
		q = rdat[7:0];
		if (n >= 20) n_errors++;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_i);
	endtask
	task wr8(input [2:0] a, input [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rd_chk(input [2:0] a, input [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, e)
	endtask
	// Waits a bounded time for one request line.
	task wait_irq(input int b);
		for (int n = 0; n < 3000 && irq[b] !== 1'b1; n++) @(posedge clk_i);
	endtask
	task t_regs;
		wr8(3'h1, 8'hff);
		rd_chk(3'h1, 8'h0f);
		wr8(3'h1, 8'h00);
		wr8(3'h2, 8'h5a);
		rd_chk(3'h2, 8'h5a);
		wr8(3'h5, 8'hff);
		rd_chk(3'h5, 8'h07);
		rd_chk(3'h6, 8'h00);
	endtask
	// Compare A match sets its flag; mask, global gate, clears.
	task t_match;
		wr8(3'h3, 8'h14);
		wr8(3'h4, 8'h80);
		wr8(3'h2, 8'h10);
		wr8(3'h5, 8'h02);
		wr8(3'h7, 8'h01);
		wr8(3'h1, 8'h01);
		wait_irq(1);
		wr8(3'h1, 8'h00);
		`CHK(irq, 3'h2)
		rd_chk(3'h6, 8'h02);
		wr8(3'h7, 8'h00);
		tick(1);
		`CHK(irq, 3'h0)
		wr8(3'h7, 8'h01);
		wr8(3'h6, 8'h00);
		rd_chk(3'h6, 8'h02);
		ack <= 3'h2;
		tick(1);
		ack <= 3'h0;
		rd_chk(3'h6, 8'h00);
		wr8(3'h2, 8'h14);
		wr8(3'h1, 8'h01);
		tick(4);
		wr8(3'h1, 8'h00);
		rd_chk(3'h6, 8'h00);
	endtask
	// Overflow in normal mode, then a write of one clears it.
	task t_ovf;
		wr8(3'h5, 8'h01);
		wr8(3'h2, 8'hfc);
		wr8(3'h1, 8'h01);
		wait_irq(0);
		wr8(3'h1, 8'h00);
		rd_chk(3'h6, 8'h01);
		wr8(3'h6, 8'h01);
		rd_chk(3'h6, 8'h00);
	endtask
	// Force toggles A and sets B in clear-on-match mode, not in PWM.
	task t_force;
		wr8(3'h0, 8'h72);
		wr8(3'h2, 8'h33);
		wr8(3'h1, 8'hc0);
		tick(2);
		`CHK({wa, wb}, 2'b11)
		rd_chk(3'h2, 8'h33);
		rd_chk(3'h6, 8'h00);
		wr8(3'h0, 8'h71);
		wr8(3'h1, 8'hc0);
		tick(2);
		`CHK({wa, wb}, 2'b11)
		wr8(3'h0, 8'h00);
	endtask
	// Three pin pulses counted on falling, then rising edges.
	task t_ext;
		for (int m = 6; m < 8; m++) begin
			wr8(3'h2, 8'h00);
			wr8(3'h1, m[7:0]);
			repeat (3) begin
				pin <= 1'b1;
				tick(4);
				pin <= 1'b0;
				tick(4);
			end
			tick(6);
			wr8(3'h1, 8'h00);
			rd_chk(3'h2, 8'h03);
		end
	endtask
	// About ten ticks in ten divided periods for each internal divider; none when stopped.
	task t_presc;
		for (int c = 0; c < 6; c++) begin
			wr8(3'h2, 8'h00);
			wr8(3'h1, c[7:0]);
			tick(10 * dv[c]);
			wr8(3'h1, 8'h00);
			bus(1'b0, 3'h2, 8'h00);
			`CHK(c == 0 ? q == 8'h00 : q >= 8'h09 && q <= (c == 1 ? 8'h0f : 8'h0b), 1'b1)
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 8; i++) rd_chk(i[2:0], 8'h00);
		t_regs;
		t_match;
		t_ovf;
		t_force;
		t_ext;
		t_presc;
		test_done;
	end
endmodule
